//--- floppy_framer_params.svh
// Constants of the floppy sector field framer
// Behaviour
// - MFM address field: three A1/0A syncs, FE
// - FM address field: FE mark under C7 clock
// - Then track, head, sector, length, two CRC
// - Length from bits 1:0 only, 128 to 1024
// - FM mark needs a preceding zero byte
// - Track mismatch: seek error, recalibrate, reseek
// - Skip other sectors until match or timeout
// - Compare head only when command asks
// - Data mark after syncs, then payload, CRC
// - LSB-only variant pairs F8/FA and F9/FB
// - Invert payload bytes only, never framing bytes
// - CRC-16 1021, preset FFFF, MSB first
// - CRC written high byte first, checked on read
// - FM address CRC covers mark plus four bytes
// - FM data CRC covers mark and inverted payload
// - MFM CRC also covers the three syncs
// - Bytes carried MSB first, no framing bits
`ifndef FLOPPY_FRAMER_PARAMS_SVH
`define FLOPPY_FRAMER_PARAMS_SVH

`define MARK_ADDR 8'hfe
`define MARK_DATA 8'hfb
`define MARK_DATA_MIN 8'hf8
`define SYNC_BYTE 8'ha1
`define SYNC_COUNT 2'd3
`define CLK_MFM_SYNC 8'h0a
`define CLK_FM_MARK 8'hc7
`define CLK_FM_NORMAL 8'hff
`define CLK_MFM_NORMAL 8'h00
`define CRC_POLY 16'h1021
`define CRC_PRESET 16'hffff
`define LEN_BASE 11'd128
`define LEN_CODE_MSB 1
`define ID_BYTES 11'd4
`define GAP_BYTES 11'd12
`define CLK_MHZ 200
`define SEARCH_TIMEOUT_MS 1000

`endif

//--- floppy_framer_pkg.sv
// Types and CRC step of the floppy sector field framer
`default_nettype none
package floppy_framer_pkg;
`include "floppy_framer_params.svh"

   typedef enum logic [3:0] {
      ST_IDLE, ST_HUNT, ST_ADDR, ST_DHUNT, ST_DATA,
      ST_WGAP, ST_WSYNC, ST_WMARK, ST_WBODY, ST_WCRCH, ST_WCRCL
   } fsm_state_e;

   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_FORMAT} cmd_op_e;

   typedef struct packed {
      fsm_state_e state;
      cmd_op_e op;
      logic mfm;
      logic headCheck;
      logic [7:0] track;
      logic [7:0] head;
      logic [7:0] sector;
      logic [1:0] lenCode;
      logic [1:0] syncCnt;
      logic prevZero;
      logic [15:0] crc;
      logic [10:0] cnt;
      logic [3:0][7:0] idField;
      logic [31:0] timer;
      logic [7:0] wrByte;
      logic [7:0] wrClkPat;
      logic wrValid;
      logic hostInReady;
      logic rdReady;
      logic [1:0][7:0] outData;
      logic [1:0] outCnt;
      logic outValid;
      logic busy;
      logic done;
      logic crcError;
      logic markError;
      logic deletedMark;
      logic timeoutError;
      logic seekError;
      logic recalReq;
      logic [1:0] foundLen;
   } framer_state_s;

   // One byte through the CRC register, MSB first
   function automatic logic [15:0] crc_byte(input logic [15:0] crcIn, input logic [7:0] b);
      logic [15:0] c;
      c = crcIn;
      for (int i = 7; i >= 0; i--) begin
         if (c[15] ^ b[i]) begin
            c = {c[14:0], 1'b0} ^ `CRC_POLY;
         end else begin
            c = {c[14:0], 1'b0};
         end
      end
      return c;
   endfunction
endpackage
`default_nettype wire

//--- floppy_sector_field_framer.sv
// Byte-level framer and checker for floppy address and data fields
`timescale 1ns/100ps
`default_nettype none
`include "floppy_framer_params.svh"

module floppy_sector_field_framer
   import floppy_framer_pkg::*;
#(
   parameter int unsigned SearchTimeoutCycles = `SEARCH_TIMEOUT_MS * 1000 * `CLK_MHZ,
   parameter bit LsbOnlyMark = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   // Command side
   input wire logic cmdStart,
   input wire cmd_op_e cmdOp,
   input wire logic cmdMfm,
   input wire logic cmdHeadCheck,
   input wire logic [7:0] cmdTrack,
   input wire logic [7:0] cmdHead,
   input wire logic [7:0] cmdSector,
   input wire logic [1:0] cmdLenCode,
   output logic busy,
   output logic done,
   output logic crcError,
   output logic markError,
   output logic deletedMark,
   output logic timeoutError,
   output logic seekError,
   output logic recalReq,
   output logic [1:0] foundLen,
   // Host payload in (write)
   input wire logic [7:0] hostInByte,
   input wire logic hostInValid,
   output logic hostInReady,
   // Host payload out (read)
   output logic [7:0] hostOutByte,
   output logic hostOutValid,
   input wire logic hostOutReady,
   // Decoder side
   input wire logic [7:0] rdByte,
   input wire logic [7:0] rdClkPat,
   input wire logic rdValid,
   output logic rdReady,
   // Encoder side
   output logic [7:0] wrByte,
   output logic [7:0] wrClkPat,
   output logic wrValid,
   input wire logic wrReady
);

   if (SearchTimeoutCycles < 2) begin : g_chk_timeout
      $error("SearchTimeoutCycles must be at least 2");
   end

   framer_state_s q;
   framer_state_s d;

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   logic take;
   logic isSync;
   logic markSeen;
   logic [15:0] markCrc;
   logic [15:0] rdCrc;
   logic [10:0] payLen;
   logic wrFree;
   logic [7:0] normClk;
   logic [7:0] emitByte;
   logic emit;
   logic finish;

   always_comb begin
      d = q;
      d.done = 1'b0;
      d.recalReq = 1'b0;
      finish = 1'b0;
      emit = 1'b0;
      emitByte = 8'h00;
      take = rdValid && q.rdReady;
      // Sync byte: A1 data under 0A clock, MFM only
      isSync = q.mfm && rdClkPat == `CLK_MFM_SYNC && rdByte == `SYNC_BYTE;
      // FM mark under C7 clock needs a zero byte right before it
      markSeen = take && ((!q.mfm && rdClkPat == `CLK_FM_MARK && q.prevZero)
                 || (q.mfm && q.syncCnt == `SYNC_COUNT && !isSync));
      markCrc = crc_byte(q.mfm ? q.crc : `CRC_PRESET, rdByte);
      rdCrc = crc_byte(q.crc, rdByte);
      payLen = `LEN_BASE << q.foundLen;
      wrFree = !q.wrValid || wrReady;
      normClk = q.mfm ? `CLK_MFM_NORMAL : `CLK_FM_NORMAL;

      if (q.wrValid && wrReady) begin
         d.wrValid = 1'b0;
      end
      if (q.outCnt != 2'd0 && hostOutReady) begin
         d.outData[0] = q.outData[1];
         d.outCnt = q.outCnt - 2'd1;
      end

      // Sync and zero tracking while hunting for marks
      if (take && (q.state == ST_HUNT || q.state == ST_DHUNT)) begin
         d.prevZero = rdByte == 8'h00 && rdClkPat != `CLK_FM_MARK;
         if (isSync) begin
            d.crc = crc_byte(q.syncCnt == 2'd0 ? `CRC_PRESET : q.crc, rdByte);
            if (q.syncCnt != `SYNC_COUNT) begin
               d.syncCnt = q.syncCnt + 2'd1;
            end
         end else begin
            d.syncCnt = 2'd0;
         end
      end

      // Search timeout covers hunting and address parsing
      if (q.state == ST_HUNT || q.state == ST_ADDR || q.state == ST_DHUNT) begin
         d.timer = q.timer + 32'd1;
         if (q.timer == SearchTimeoutCycles - 1) begin
            d.timeoutError = 1'b1;
            finish = 1'b1;
         end
      end

      case (q.state)
         ST_IDLE: begin
            if (cmdStart) begin
               d.op = cmdOp;
               d.mfm = cmdMfm;
               d.headCheck = cmdHeadCheck;
               d.track = cmdTrack;
               d.head = cmdHead;
               d.sector = cmdSector;
               d.lenCode = cmdLenCode;
               d.busy = 1'b1;
               d.timer = 32'd0;
               d.cnt = 11'd0;
               d.syncCnt = 2'd0;
               d.prevZero = 1'b0;
               d.crcError = 1'b0;
               d.markError = 1'b0;
               d.deletedMark = 1'b0;
               d.timeoutError = 1'b0;
               d.seekError = 1'b0;
               d.state = cmdOp == OP_FORMAT ? ST_WGAP : ST_HUNT;
            end
         end
         ST_HUNT, ST_DHUNT: begin
            if (markSeen && rdByte == `MARK_ADDR) begin
               d.crc = markCrc;
               d.cnt = 11'd0;
               d.state = ST_ADDR;
            end else if (markSeen && q.state == ST_DHUNT && rdByte >= `MARK_DATA_MIN
                         && rdByte <= `MARK_DATA) begin
               d.crc = markCrc;
               d.cnt = 11'd0;
               d.markError = rdByte != `MARK_DATA;
               if (LsbOnlyMark) begin
                  d.deletedMark = !rdByte[0];
               end else begin
                  d.deletedMark = rdByte != `MARK_DATA;
               end
               d.state = ST_DATA;
            end
            if (markSeen) begin
               d.syncCnt = 2'd0;
               d.prevZero = 1'b0;
            end
         end
         ST_ADDR: begin
            if (take) begin
               d.crc = rdCrc;
               if (q.cnt < `ID_BYTES) begin
                  d.idField[q.cnt[1:0]] = rdByte;
               end
               d.cnt = q.cnt + 11'd1;
               if (q.cnt == `ID_BYTES + 11'd1) begin
                  d.state = ST_HUNT;
                  d.syncCnt = 2'd0;
                  d.prevZero = 1'b0;
                  if (rdCrc != 16'h0000) begin
                     d.crcError = 1'b1;
                  end else if (q.idField[0] != q.track) begin
                     d.seekError = 1'b1;
                     d.recalReq = 1'b1;
                  end else if (q.idField[2] != q.sector) begin
                     d.state = ST_HUNT;
                  end else if (q.headCheck && q.idField[1] != q.head) begin
                     d.state = ST_HUNT;
                  end else begin
                     d.crcError = 1'b0;
                     d.seekError = 1'b0;
                     d.foundLen = q.idField[3][`LEN_CODE_MSB:0];
                     d.cnt = 11'd0;
                     d.state = q.op == OP_WRITE ? ST_WGAP : ST_DHUNT;
                  end
               end
            end
         end
         ST_DATA: begin
            if (take) begin
               d.crc = rdCrc;
               d.cnt = q.cnt + 11'd1;
               if (q.cnt < payLen) begin
                  d.outData[d.outCnt[0]] = ~rdByte;
                  d.outCnt = d.outCnt + 2'd1;
               end
               if (q.cnt == payLen + 11'd1) begin
                  d.crcError = rdCrc != 16'h0000;
                  finish = 1'b1;
               end
            end
         end
         ST_WGAP: begin
            if (wrFree) begin
               emit = 1'b1;
               emitByte = 8'h00;
               d.wrClkPat = normClk;
               d.cnt = q.cnt + 11'd1;
               if (q.cnt == `GAP_BYTES - 11'd1) begin
                  d.cnt = 11'd0;
                  d.state = q.mfm ? ST_WSYNC : ST_WMARK;
               end
            end
         end
         ST_WSYNC: begin
            if (wrFree) begin
               emit = 1'b1;
               emitByte = `SYNC_BYTE;
               d.wrClkPat = `CLK_MFM_SYNC;
               d.crc = crc_byte(q.cnt == 11'd0 ? `CRC_PRESET : q.crc, `SYNC_BYTE);
               d.cnt = q.cnt + 11'd1;
               if (q.cnt == 11'(`SYNC_COUNT) - 11'd1) begin
                  d.cnt = 11'd0;
                  d.state = ST_WMARK;
               end
            end
         end
         ST_WMARK: begin
            if (wrFree) begin
               emit = 1'b1;
               emitByte = q.op == OP_FORMAT ? `MARK_ADDR : `MARK_DATA;
               d.wrClkPat = q.mfm ? `CLK_MFM_NORMAL : `CLK_FM_MARK;
               d.crc = crc_byte(q.mfm ? q.crc : `CRC_PRESET, emitByte);
               d.cnt = 11'd0;
               d.state = ST_WBODY;
            end
         end
         ST_WBODY: begin
            if (q.op == OP_FORMAT) begin
               if (wrFree) begin
                  emit = 1'b1;
                  case (q.cnt[1:0])
                     2'd0: emitByte = q.track;
                     2'd1: emitByte = q.head;
                     2'd2: emitByte = q.sector;
                     default: emitByte = {6'h00, q.lenCode};
                  endcase
                  d.wrClkPat = normClk;
                  d.crc = crc_byte(q.crc, emitByte);
                  d.cnt = q.cnt + 11'd1;
                  if (q.cnt == `ID_BYTES - 11'd1) begin
                     d.state = ST_WCRCH;
                  end
               end
            end else if (q.hostInReady && hostInValid) begin
               emit = 1'b1;
               emitByte = ~hostInByte;
               d.wrClkPat = normClk;
               d.crc = crc_byte(q.crc, emitByte);
               d.cnt = q.cnt + 11'd1;
               if (q.cnt == payLen - 11'd1) begin
                  d.state = ST_WCRCH;
               end
            end
         end
         ST_WCRCH: begin
            if (wrFree) begin
               emit = 1'b1;
               emitByte = q.crc[15:8];
               d.wrClkPat = normClk;
               d.state = ST_WCRCL;
            end
         end
         ST_WCRCL: begin
            if (wrFree) begin
               emit = 1'b1;
               emitByte = q.crc[7:0];
               d.wrClkPat = normClk;
               finish = 1'b1;
            end
         end
         default: begin
            d.state = ST_IDLE;
         end
      endcase

      if (emit) begin
         d.wrByte = emitByte;
         d.wrValid = 1'b1;
      end
      if (finish) begin
         d.state = ST_IDLE;
         d.busy = 1'b0;
         d.done = 1'b1;
      end
      d.hostInReady = d.state == ST_WBODY && q.op == OP_WRITE && !d.wrValid;
      d.rdReady = d.outCnt != 2'd2;
      d.outValid = d.outCnt != 2'd0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.state <= ST_IDLE;
         q.op <= OP_READ;
         q.crc <= `CRC_PRESET;
         q.rdReady <= 1'b1;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign busy = q.busy;
   assign done = q.done;
   assign crcError = q.crcError;
   assign markError = q.markError;
   assign deletedMark = q.deletedMark;
   assign timeoutError = q.timeoutError;
   assign seekError = q.seekError;
   assign recalReq = q.recalReq;
   assign foundLen = q.foundLen;
   assign hostInReady = q.hostInReady;
   assign hostOutByte = q.outData[0];
   assign hostOutValid = q.outValid;
   assign rdReady = q.rdReady;
   assign wrByte = q.wrByte;
   assign wrClkPat = q.wrClkPat;
   assign wrValid = q.wrValid;

endmodule
`default_nettype wire

//--- floppy_framer_monitor.sv
// Port checker of the floppy sector field framer
`timescale 1ns/100ps
`default_nettype none
module floppy_framer_monitor #(
   parameter int unsigned SearchTimeoutCycles = 2000,
   parameter bit LsbOnlyMark = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmdStart,
   input wire logic busy,
   input wire logic done,
   input wire logic crcError,
   input wire logic markError,
   input wire logic deletedMark,
   input wire logic seekError,
   input wire logic recalReq,
   input wire logic [7:0] hostInByte,
   input wire logic hostInValid,
   input wire logic hostInReady,
   input wire logic [7:0] wrByte,
   input wire logic [7:0] wrClkPat,
   input wire logic wrValid,
   input wire logic wrReady
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence sTaken;
      cmdStart && !busy;
   endsequence
   sequence sClean;
      busy && !crcError && !markError && !seekError;
   endsequence
   AST_START_CLEAN: assert property (sTaken |=> sClean)
      else $error("flags not cleared after start");
   AST_DONE_END: assert property (done |-> !busy && $past(busy) ##1 !done)
      else $error("done without busy");
   AST_RECAL_SEEK: assert property (recalReq |-> seekError ##1 !recalReq)
      else $error("recalibrate pulse without seek flag");
   AST_WR_HOLD: assert property (wrValid && !wrReady |=> wrValid && $stable(wrByte) && $stable(wrClkPat))
      else $error("encoder byte dropped");
   AST_IN_INVERT: assert property (hostInValid && hostInReady |=> wrValid && wrByte == ~$past(hostInByte))
      else $error("payload byte not inverted");
   AST_MARK_KIND: assert property (markError && !LsbOnlyMark |-> deletedMark)
      else $error("unusual mark not reported as deleted");
   AST_SYNC_CLOCK: assert property (wrValid && wrClkPat == 8'h0a |-> wrByte == 8'ha1)
      else $error("sync clock on wrong byte");
   AST_FM_MARK: assert property (wrValid && wrClkPat == 8'hc7 |-> wrByte inside {8'hfe, 8'hfb})
      else $error("mark clock on wrong byte");
endmodule
bind floppy_sector_field_framer floppy_framer_monitor #(.SearchTimeoutCycles(SearchTimeoutCycles),
   .LsbOnlyMark(LsbOnlyMark)) u_mon (.clk(clk), .rst_n(rst_n), .cmdStart(cmdStart), .busy(busy), .done(done),
   .crcError(crcError), .markError(markError), .deletedMark(deletedMark), .seekError(seekError),
   .recalReq(recalReq), .hostInByte(hostInByte), .hostInValid(hostInValid), .hostInReady(hostInReady),
   .wrByte(wrByte), .wrClkPat(wrClkPat), .wrValid(wrValid), .wrReady(wrReady));
`default_nettype wire

//--- floppy_disk_model.sv
// Model of the bit-cell encoder and decoder at the head
`timescale 1ns/100ps
`default_nettype none
module floppy_disk_model (
   input wire logic clk,
   input wire logic slow,
   output logic [7:0] rdByte,
   output logic [7:0] rdClkPat,
   output logic rdValid,
   input wire logic rdReady,
   input wire logic [7:0] wrByte,
   input wire logic [7:0] wrClkPat,
   input wire logic wrValid,
   output logic wrReady
);
   logic [15:0] rdQ[$];
   logic [15:0] wrQ[$];
   logic took = 1'b0;
   initial begin
      rdByte = 8'h00;
      rdClkPat = 8'hff;
      rdValid = 1'b0;
      wrReady = 1'b1;
   end
   always @(posedge clk) begin
      took <= rdValid && rdReady;
      if (wrValid && wrReady) wrQ.push_back({wrClkPat, wrByte});
   end
   always @(negedge clk) begin
      wrReady = !slow || $urandom_range(0, 2) != 0;
      if (took || !rdValid) begin
         if (rdQ.size() > 0 && (!slow || $urandom_range(0, 3) != 0)) begin
            {rdClkPat, rdByte} = rdQ.pop_front();
            rdValid = 1'b1;
         end else begin
            rdValid = 1'b0;
            rdByte = ~rdByte;
         end
      end
   end
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench of the floppy sector field framer
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import floppy_framer_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmdStart = 1'b0;
   cmd_op_e cmdOp = OP_READ;
   logic cmdMfm = 1'b0;
   logic cmdHeadCheck = 1'b0;
   logic [7:0] cmdTrack = 8'h00;
   logic [7:0] cmdHead = 8'h00;
   logic [7:0] cmdSector = 8'h00;
   logic [1:0] cmdLenCode = 2'h0;
   logic busy, done, crcError, markError, deletedMark, timeoutError, seekError, recalReq;
   logic [1:0] foundLen;
   logic [7:0] hostInByte = 8'h00;
   logic hostInValid = 1'b0;
   logic hostOutReady = 1'b1;
   logic slow = 1'b0;
   logic tk = 1'b0;
   logic hostInReady, hostOutValid, rdValid, rdReady, wrValid, wrReady;
   logic [7:0] hostOutByte, rdByte, rdClkPat, wrByte, wrClkPat;
   logic [7:0] inQ[$];
   logic [7:0] body[$];
   logic [15:0] f[$];
   logic [15:0] eo[$];
   logic [15:0] oq[$];
   int fail_count = 0;
   int compares = 0;
   int recals = 0;
   int k;

   floppy_sector_field_framer #(.SearchTimeoutCycles(2000)) i_floppy_sector_field_framer (
      .clk(clk), .rst_n(rst_n), .cmdStart(cmdStart), .cmdOp(cmdOp), .cmdMfm(cmdMfm),
      .cmdHeadCheck(cmdHeadCheck), .cmdTrack(cmdTrack), .cmdHead(cmdHead), .cmdSector(cmdSector),
      .cmdLenCode(cmdLenCode), .busy(busy), .done(done), .crcError(crcError), .markError(markError),
      .deletedMark(deletedMark), .timeoutError(timeoutError), .seekError(seekError), .recalReq(recalReq),
      .foundLen(foundLen), .hostInByte(hostInByte), .hostInValid(hostInValid), .hostInReady(hostInReady),
      .hostOutByte(hostOutByte), .hostOutValid(hostOutValid), .hostOutReady(hostOutReady),
      .rdByte(rdByte), .rdClkPat(rdClkPat), .rdValid(rdValid), .rdReady(rdReady),
      .wrByte(wrByte), .wrClkPat(wrClkPat), .wrValid(wrValid), .wrReady(wrReady));
   floppy_disk_model disk (.clk(clk), .slow(slow), .rdByte(rdByte), .rdClkPat(rdClkPat), .rdValid(rdValid),
      .rdReady(rdReady), .wrByte(wrByte), .wrClkPat(wrClkPat), .wrValid(wrValid), .wrReady(wrReady));

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      tk <= hostInValid && hostInReady;
      if (hostOutValid && hostOutReady) oq.push_back({8'h00, hostOutByte});
      if (recalReq === 1'b1) recals++;
   end
   always @(negedge clk) begin
      hostOutReady = !slow || $urandom_range(0, 3) != 0;
      if (tk) void'(inQ.pop_front());
      hostInValid = inQ.size() > 0;
      hostInByte = hostInValid ? inQ[0] : ~hostInByte;
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
      end
      return c;
   endfunction
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cmpq(input string n, input logic [15:0] e[$], input logic [15:0] g[$]);
      chk(n, e.size(), g.size());
      foreach (e[i]) if (i < g.size()) chk(n, e[i], g[i]);
   endtask
   task automatic field(input logic mfm, input logic [7:0] mark, input logic [7:0] z, input logic bad);
      logic [15:0] c;
      logic [7:0] n;
      c = 16'hffff;
      n = mfm ? 8'h00 : 8'hff;
      repeat (12) f.push_back({n, z});
      if (mfm) begin
         repeat (3) begin
            f.push_back(16'h0aa1);
            c = crc8(c, 8'ha1);
         end
      end
      f.push_back({mfm ? n : 8'hc7, mark});
      c = crc8(c, mark);
      foreach (body[i]) begin
         f.push_back({n, body[i]});
         c = crc8(c, body[i]);
      end
      c[0] = c[0] ^ bad;
      f.push_back({n, c[15:8]});
      f.push_back({n, c[7:0]});
   endtask
   task automatic send(input logic mfm, input logic [7:0] mark, input logic [7:0] z, input logic bad);
      field(mfm, mark, z, bad);
      disk.rdQ = {disk.rdQ, f};
      f = {};
   endtask
   task automatic start(input cmd_op_e op, input logic mfm, input logic hc, input logic [7:0] s);
      @(negedge clk);
      cmdOp = op;
      cmdMfm = mfm;
      cmdHeadCheck = hc;
      cmdSector = s;
      cmdStart = 1'b1;
      @(negedge clk);
      cmdStart = 1'b0;
   endtask
   task automatic fin();
      for (k = 0; k < 9000 && done !== 1'b1; k++) @(negedge clk);
      chk("done", 1, done);
      repeat (40) @(negedge clk);
   endtask
   task automatic rdend(input logic [4:0] e);
      foreach (body[i]) eo.push_back({8'h00, ~body[i]});
      cmpq("hostOut", eo, oq);
      chk("flags", e, {crcError, markError, deletedMark, timeoutError, seekError});
      eo = {};
      oq = {};
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      #300000;
      fail_count++;
      wrap_up();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(76));
      repeat (12) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      start(OP_READ, 1'b0, 1'b0, 8'h01);
      body = '{8'h00, 8'h01, 8'h01, 8'h00};
      send(1'b0, 8'hfe, 8'h00, 1'b0);
      body = {};
      repeat (128) body.push_back(8'hff);
      send(1'b0, 8'hfb, 8'h00, 1'b0);
      fin();
      rdend(5'b00000);
      chk("foundLen", 2'h0, foundLen);
      slow = 1'b1;
      {cmdTrack, cmdHead} = 16'h0500;
      start(OP_READ, 1'b1, 1'b1, 8'h07);
      body = '{8'h04, 8'h00, 8'h07, 8'hfd};
      send(1'b1, 8'hfe, 8'h00, 1'b0);
      body = '{8'h05, 8'h01, 8'h07, 8'hfd};
      send(1'b1, 8'hfe, 8'h00, 1'b0);
      body = '{8'h05, 8'h00, 8'h12, 8'hfd};
      send(1'b1, 8'hfe, 8'h00, 1'b0);
      body = '{8'h05, 8'h00, 8'h07, 8'hfd};
      send(1'b1, 8'hfe, 8'h00, 1'b1);
      send(1'b1, 8'hfe, 8'h00, 1'b0);
      body = {};
      repeat (256) body.push_back(8'($urandom));
      send(1'b1, 8'hf8, 8'h00, 1'b0);
      fin();
      rdend(5'b01100);
      chk("foundLen", 2'h1, foundLen);
      chk("recalCount", 1, recals);
      start(OP_READ, 1'b0, 1'b0, 8'h02);
      body = '{8'h05, 8'h00, 8'h02, 8'h00};
      send(1'b0, 8'hfe, 8'h55, 1'b0);
      body = {};
      fin();
      rdend(5'b00010);
      for (int m = 0; m < 2; m++) begin
         {cmdTrack, cmdHead, cmdLenCode} = {8'h27, 8'h01, 2'h3};
         start(OP_FORMAT, m[0], 1'b0, 8'h1a);
         fin();
         body = '{8'h27, 8'h01, 8'h1a, 8'h03};
         field(m[0], 8'hfe, 8'h00, 1'b0);
         cmpq("formatStream", f, disk.wrQ);
         f = {};
         disk.wrQ = {};
      end
      {cmdTrack, cmdHead} = 16'h0500;
      start(OP_WRITE, 1'b0, 1'b0, 8'h03);
      body = '{8'h05, 8'h00, 8'h03, 8'h00};
      send(1'b0, 8'hfe, 8'h00, 1'b0);
      body = {};
      repeat (128) begin
         inQ.push_back(8'($urandom));
         body.push_back(~inQ[$]);
      end
      fin();
      field(1'b0, 8'hfb, 8'h00, 1'b0);
      cmpq("writeStream", f, disk.wrQ);
      wrap_up();
   end
endmodule
`default_nettype wire
